/* sim/mdsr_host_model.sv */
// Behavioural serial host that reads and writes the bank
`timescale 1ns/1ps
`default_nettype none
module mdsr_host_model #(
   parameter logic [6:0] ADDR = 7'h2a  // Arbitrary bus address
) (
   input  wire logic clk_sys_i,
   input  wire logic sda_i,
   output var logic  scl_o,
   output var logic  sda_o
);
   // Idle: clock stands high, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Quarter bit of 4 clocks keeps both phases over 6 clocks
   task automatic qw;
      repeat (4) @(posedge clk_sys_i);
      #1;
   endtask : qw
   task automatic bt(input logic b, output logic r);
      sda_o = b;
      qw();
      scl_o = 1'b1;
      qw();
      r = sda_i;
      qw();
      scl_o = 1'b0;
      qw();
   endtask : bt
   // Start and repeated start alike
   task automatic st;
      sda_o = 1'b1;
      qw();
      scl_o = 1'b1;
      qw();
      sda_o = 1'b0;
      qw();
      scl_o = 1'b0;
      qw();
   endtask : st
   task automatic sp;
      sda_o = 1'b0;
      qw();
      scl_o = 1'b1;
      qw();
      sda_o = 1'b1;
      qw();
   endtask : sp
   task automatic by(input logic [7:0] w, input logic ab, output logic [7:0] r);
      logic ak;
      for (int i = 7; i >= 0; i--) bt(w[i], r[i]);
      bt(ab, ak);
   endtask : by
   // Only offsets the caller names are touched
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      logic [7:0] r;
      st();
      by({ADDR, 1'b0}, 1'b1, r);
      by(o, 1'b1, r);
      by(d, 1'b1, r);
      sp();
   endtask : wr
   task automatic rd(input logic [7:0] o, output logic [7:0] d);
      logic [7:0] r;
      st();
      by({ADDR, 1'b0}, 1'b1, r);
      by(o, 1'b1, r);
      st();
      by({ADDR, 1'b1}, 1'b1, r);
      by(8'hff, 1'b1, d);
      sp();
   endtask : rd
endmodule : mdsr_host_model
`default_nettype wire

/* sim/mdsr_top_properties.sv */
// Port checker for the status register bank
`timescale 1ns/1ps
`default_nettype none
module mdsr_top_properties (
   input wire logic        clk_sys_i,
   input wire logic        nrst_i,
   input wire logic        ce_i,
   input wire logic        scl_i,
   input wire logic        stall_det_i,
   input wire logic        overcurrent_det_i,
   input wire logic        overvoltage_det_i,
   input wire logic        thermal_det_i,
   input wire logic        fault_out_low_pin_n_o,
   input wire logic        fault_out_low_pin_oe_o,
   input wire logic [7:0]  fault_enable_config_o,
   input wire logic [15:0] inrush_time_o,
   input wire logic [7:0]  mode_config_o,
   input wire logic [7:0]  control_config_o
);
   // *****
   // Properties
   // *****
   // A frozen clock enable stretches every latency, so it disables too
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i || !ce_i);

   property p_pin_pair;
      fault_out_low_pin_n_o == !fault_out_low_pin_oe_o;
   endproperty
   a_pin_pair: assert property (p_pin_pair)
      else $error("fault pin level and enable disagree");

   property p_pin_cause;
      $rose(fault_out_low_pin_oe_o) |->
         $past(stall_det_i || overcurrent_det_i || overvoltage_det_i || thermal_det_i, 4);
   endproperty
   a_pin_cause: assert property (p_pin_cause)
      else $error("fault pin pulled without a detected fault");

   property p_stall;
      (stall_det_i && fault_enable_config_o[5]) [*4] |-> ##[0:1] fault_out_low_pin_oe_o;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall did not pull the fault pin");

   property p_overcur;
      overcurrent_det_i [*4] |-> ##[0:1] fault_out_low_pin_oe_o;
   endproperty
   a_overcur: assert property (p_overcur)
      else $error("overcurrent did not pull the fault pin");

   property p_overvolt;
      (overvoltage_det_i && fault_enable_config_o[6]) [*4] |-> ##[0:1] fault_out_low_pin_oe_o;
   endproperty
   a_overvolt: assert property (p_overvolt)
      else $error("overvoltage did not pull the fault pin");

   property p_thermal;
      thermal_det_i [*4] |-> ##[0:1] fault_out_low_pin_oe_o;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("thermal event did not pull the fault pin");

   property p_cfg_rst;
      $rose(nrst_i) |-> fault_enable_config_o == 8'h60 && mode_config_o == 8'h63;
   endproperty
   a_cfg_rst: assert property (p_cfg_rst)
      else $error("configuration reset value wrong");

   property p_clr_self;
      fault_enable_config_o[3:1] == 3'b000;
   endproperty
   a_clr_self: assert property (p_clr_self)
      else $error("clear bit or spare bits read back set");

   // Register writes land only while the serial clock is held low
   property p_cfg_quiet;
      $changed({fault_enable_config_o, inrush_time_o, mode_config_o, control_config_o})
         |-> !scl_i && $past(!scl_i, 3);
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet)
      else $error("configuration changed outside a write");
endmodule : mdsr_top_properties

bind mdsr_top mdsr_top_properties mdsr_top_properties_i (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .scl_i(scl_i),
   .stall_det_i(stall_det_i), .overcurrent_det_i(overcurrent_det_i),
   .overvoltage_det_i(overvoltage_det_i), .thermal_det_i(thermal_det_i),
   .fault_out_low_pin_n_o(fault_out_low_pin_n_o),
   .fault_out_low_pin_oe_o(fault_out_low_pin_oe_o),
   .fault_enable_config_o(fault_enable_config_o), .inrush_time_o(inrush_time_o),
   .mode_config_o(mode_config_o), .control_config_o(control_config_o));
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {logic [7:0] ofs; logic [7:0] v; logic [7:0] e;} mdsr_row_t;
   logic       clk_sys_i = 1'b0;
   logic       nrst_i    = 1'b0;
   logic [3:0] det       = 4'h0;  // Stall, overcurrent, overvoltage, thermal
   logic       supply    = 1'b1;
   logic [7:0] val       = 8'h00;
   logic       reg_on    = 1'b1;  // Regulation running
   logic [15:0] inrush;
   logic       scl, hsda, sda_oe, sda_d, pin_n;
   logic [7:0] rdv;
   int         error_cnt = 0;
   int         checks_done = 0;
   int         cyc = 0;
   wire logic  sda_w = sda_oe ? sda_d : hsda;  // Pull-up when nobody pulls
   mdsr_row_t  rows [10] = '{'{8'h00, 8'h00, 8'h00}, '{8'h09, 8'h00, 8'h60},
      '{8'h0c, 8'h00, 8'h63}, '{8'h01, 8'ha5, 8'ha5}, '{8'h04, 8'he4, 8'he4},
      '{8'h04, 8'hff, 8'hff}, '{8'h05, 8'hc0, 8'hc0}, '{8'h06, 8'hff, 8'h3f},
      '{8'h06, 8'h2a, 8'h2a}, '{8'h02, 8'hff, 8'h00}};

   always #20 clk_sys_i = ~clk_sys_i;

   mdsr_top mdsr_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe),
      .stall_det_i(det[3]), .overcurrent_det_i(det[2]),
      .overvoltage_det_i(det[1]), .thermal_det_i(det[0]),
      .supply_above_uv_i(supply), .speed_est_i(val),
      .terminal_voltage_code_i(val), .winding_current_code_i(val),
      .duty_cycle_i(val[5:0]), .regulation_active_i(reg_on),
      .fault_out_low_pin_n_o(pin_n), .fault_out_low_pin_oe_o(),
      .fault_enable_config_o(), .inrush_time_o(inrush), .mode_config_o(),
      .control_config_o());
   mdsr_host_model mdsr_host_model_i (.clk_sys_i(clk_sys_i), .sda_i(sda_w),
      .scl_o(scl), .sda_o(hsda));

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] o, input logic [7:0] e);
      mdsr_host_model_i.rd(o, rdv);
      chk(rdv, e);
   endtask : rdc
   task automatic pulse(input logic [3:0] d);
      det = d;
      repeat (6) @(posedge clk_sys_i);
      #1;
      det = 4'h0;
   endtask : pulse
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   // Hang guard, well above the ~23k clocks the tests need
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys_i);
      #1;
      nrst_i = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1;
      foreach (rows[i]) begin
         val = rows[i].v;
         rdc(rows[i].ofs, rows[i].e);
      end
      // Duty keeps its last captured value while regulation is off
      reg_on = 1'b0;
      val    = 8'h15;
      rdc(8'h06, 8'h3f);
      reg_on = 1'b1;
      // Configuration bytes 0Ah to 0Dh take a write and read it back
      for (int k = 10; k < 14; k++) begin
         mdsr_host_model_i.wr(8'(k), 8'(k * 17));
         rdc(8'(k), 8'(k * 17));
      end
      chk(inrush[15:8], 8'hbb);
      $display("test readouts done");
      // Each detector sets its own sticky bit; first clear sets power-up
      for (int k = 0; k < 4; k++) begin
         pulse(4'h1 << k);
         rdc(8'h00, 8'h80 | (8'h04 << k) | {6'h00, k > 0, 1'b0});
         chk({7'h00, pin_n}, 8'h00);
         mdsr_host_model_i.wr(8'h09, 8'h62);
         rdc(8'h00, 8'h02);
         chk({7'h00, pin_n}, 8'h01);
      end
      $display("test faults done");
      // Status writes are dropped; stall disabled stays silent
      mdsr_host_model_i.wr(8'h00, 8'hff);
      mdsr_host_model_i.wr(8'h09, 8'h40);
      pulse(4'h8);
      rdc(8'h00, 8'h02);
      rdc(8'h09, 8'h40);
      $display("test ignored writes done");
      // Reset in mid-run with the supply low
      supply = 1'b0;
      nrst_i = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      nrst_i = 1'b1;
      rdc(8'h09, 8'h60);
      mdsr_host_model_i.wr(8'h09, 8'h62);
      rdc(8'h00, 8'h00);
      supply = 1'b1;
      mdsr_host_model_i.wr(8'h09, 8'h62);
      rdc(8'h00, 8'h02);
      $display("test reset done");
      final_report();
   end
endmodule : tb
`default_nettype wire

/* src/mdsr_flag_bank.sv */
// Bank of sticky fault flags with a common clear
`timescale 1ns/1ps
`default_nettype none
module mdsr_flag_bank #(
   parameter int N = 4
) (
   input  wire logic  clk_sys_i,
   input  wire logic  nrst_i,
   input  wire logic  ce_i,
   mdsr_flags_if.bank fl
);
   // Set beats clear so a fault in the clearing cycle survives
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fl.flags <= '0;
      end else if (ce_i) begin
         fl.flags <= (fl.flags & ~{N{fl.clr}}) | fl.set;
      end
   end
endmodule : mdsr_flag_bank
`default_nettype wire

/* src/mdsr_flags_if.sv */
// Interface between the register bank and its sticky flag bank
`timescale 1ns/1ps
`default_nettype none
interface mdsr_flags_if #(
   parameter int N = 4
);
   logic [N-1:0] set;
   logic         clr;
   logic [N-1:0] flags;

   modport bank (input set, input clr, output flags);
   modport ctl  (output set, output clr, input flags);
endinterface : mdsr_flags_if
`default_nettype wire

/* src/mdsr_pkg.sv */
// Constants and types shared by the motor driver status register bank
package mdsr_pkg;

   // ***********************************************************
   // Register offsets
   // ***********************************************************
   localparam logic [7:0] OFS_FAULT = 8'h00;
   localparam logic [7:0] OFS_SPEED = 8'h01;
   localparam logic [7:0] OFS_VOLT  = 8'h04;
   localparam logic [7:0] OFS_CURR  = 8'h05;
   localparam logic [7:0] OFS_DUTY  = 8'h06;
   localparam logic [7:0] OFS_CFG0  = 8'h09;
   localparam logic [7:0] OFS_CFG1  = 8'h0a;
   localparam logic [7:0] OFS_CFG2  = 8'h0b;
   localparam logic [7:0] OFS_CFG3  = 8'h0c;
   localparam logic [7:0] OFS_CFG4  = 8'h0d;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int BIT_FAULT        = 7;
   localparam int BIT_STALL        = 5;
   localparam int BIT_OVERCUR      = 4;
   localparam int BIT_OVERVOLT     = 3;
   localparam int BIT_THERMAL      = 2;
   localparam int BIT_PWR          = 1;
   localparam int CFG0_DRV_EN      = 7;
   localparam int CFG0_OVERVOLT_EN = 6;
   localparam int CFG0_STALL_EN    = 5;
   localparam int CFG0_CLR         = 1;
   localparam logic [7:0] CFG0_WMASK = 8'hf1;

   // Flag bank slots
   localparam int FLG_STALL    = 0;
   localparam int FLG_OVERCUR  = 1;
   localparam int FLG_OVERVOLT = 2;
   localparam int FLG_THERMAL  = 3;
   localparam int NFLAGS       = 4;

   // ***********************************************************
   // Reset values and widths
   // ***********************************************************
   localparam logic [7:0] RST_CFG0 = 8'h60;
   localparam logic [7:0] RST_CFG1 = 8'h00;
   localparam logic [7:0] RST_CFG2 = 8'h00;
   localparam logic [7:0] RST_CFG3 = 8'h63;
   localparam logic [7:0] RST_CFG4 = 8'h00;
   localparam int DUTY_W = 6;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Serial engine states, one-hot
   typedef enum logic [8:0] {
      S_IDLE  = 9'h001,
      S_ADDR  = 9'h002,
      S_AACK  = 9'h004,
      S_PTR   = 9'h008,
      S_PACK  = 9'h010,
      S_WDATA = 9'h020,
      S_WACK  = 9'h040,
      S_RDATA = 9'h080,
      S_RACK  = 9'h100
   } mdsr_state_t;

endpackage : mdsr_pkg

/* src/mdsr_sync.sv */
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module mdsr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         nrst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else if (ce_i) begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : mdsr_sync
`default_nettype wire

/* src/mdsr_top.sv */
// Status register bank of the motor driver with its serial register port
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Summary fault bit 7 high while any fault; fault pin pulled low then.
// - Without faults summary bit reads zero and fault pin is released.
// - Stall detection sets fault bit 5.
// - Overcurrent event sets fault bit 4, zero otherwise.
// - Overvoltage event sets fault bit 3, zero otherwise.
// - Thermal shutdown event sets fault bit 2, zero otherwise.
// - Power-up flag bit 1 held low after supply good until a clear.
// - First clear-faults command after power-up latches power-up flag high.
// - Offset 0x01 shows the 8-bit ripple speed estimate.
// - Offset 0x04 shows 8-bit terminal voltage code, E4h is 38 V.
// - Offset 0x05 shows 8-bit winding current code, C0h is maximum.
// - Offset 0x06 shows 6-bit bridge duty in bits 5-0, upper bits zero.
// - Duty readout only meaningful while speed or voltage regulation runs.
// - Configuration registers at 9h to Dh; first resets to 60h.
// - Writing one to clear-faults clears latched flags; bit self-clears.
module mdsr_top #(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary default address
) (
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        stall_det_i,
   input  wire logic        overcurrent_det_i,
   input  wire logic        overvoltage_det_i,
   input  wire logic        thermal_det_i,
   input  wire logic        supply_above_uv_i,
   input  wire logic [7:0]  speed_est_i,
   input  wire logic [7:0]  terminal_voltage_code_i,
   input  wire logic [7:0]  winding_current_code_i,
   input  wire logic [5:0]  duty_cycle_i,
   input  wire logic        regulation_active_i,
   output logic             fault_out_low_pin_n_o,
   output logic             fault_out_low_pin_oe_o,
   output logic [7:0]       fault_enable_config_o,
   output logic [15:0]      inrush_time_o,
   output logic [7:0]       mode_config_o,
   output logic [7:0]       control_config_o
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   mdsr_pkg::mdsr_state_t state_r;
   logic [4:0]  ev_s;
   logic [1:0]  bus_s;
   logic        scl_d_r;
   logic        sda_d_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [3:0]  cnt_r;
   logic [7:0]  sh_r;
   logic [7:0]  tx_r;
   logic [7:0]  ptr_r;
   logic        rw_r;
   logic        nack_r;
   logic        wr_stb_r;
   logic [7:0]  wr_ofs_r;
   logic [7:0]  wr_dat_r;
   logic        clr_r;
   logic        pwr_flag_r;
   logic        any_fault;
   logic [7:0]  speed_r;
   logic [7:0]  volt_r;
   logic [7:0]  curr_r;
   logic [5:0]  duty_r;
   logic [7:0]  fault_byte;
   logic [7:0]  rd_byte;
   logic [7:0]  ptr_nxt;

   mdsr_flags_if #(.N(mdsr_pkg::NFLAGS)) fl ();

   // ***********************************************************
   // Input synchronisers
   // ***********************************************************
   // Analog comparators and bus pins are asynchronous to clk_sys_i
   mdsr_sync #(.W(5)) u_ev_sync (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .ce_i      (ce_i),
      .d_i       ({supply_above_uv_i, thermal_det_i, overvoltage_det_i,
                   overcurrent_det_i, stall_det_i}),
      .q_o       (ev_s)
   );

   // Idle bus level is high, but reset to low avoids a false start
   mdsr_sync #(.W(2)) u_bus_sync (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .ce_i      (ce_i),
      .d_i       ({scl_i, sda_i}),
      .q_o       (bus_s)
   );

   // Delayed copies for edge detection on the synchronised lines
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_d_r <= 1'b0;
         sda_d_r <= 1'b0;
      end else if (ce_i) begin
         scl_d_r <= bus_s[1];
         sda_d_r <= bus_s[0];
      end
   end

   // Bus conditions
   assign scl_rise  = bus_s[1] & ~scl_d_r;
   assign scl_fall  = ~bus_s[1] & scl_d_r;
   assign start_det = bus_s[1] & scl_d_r & sda_d_r & ~bus_s[0];
   assign stop_det  = bus_s[1] & scl_d_r & ~sda_d_r & bus_s[0];
   assign ptr_nxt   = ptr_r + 8'h01;

   // ***********************************************************
   // Fault flags
   // ***********************************************************
   // Disabled detectors never set their flag
   assign fl.set[mdsr_pkg::FLG_STALL] =
      ev_s[0] & fault_enable_config_o[mdsr_pkg::CFG0_STALL_EN];
   assign fl.set[mdsr_pkg::FLG_OVERCUR] = ev_s[1];
   assign fl.set[mdsr_pkg::FLG_OVERVOLT] =
      ev_s[2] & fault_enable_config_o[mdsr_pkg::CFG0_OVERVOLT_EN];
   assign fl.set[mdsr_pkg::FLG_THERMAL] = ev_s[3];
   assign fl.clr = clr_r;

   mdsr_flag_bank #(.N(mdsr_pkg::NFLAGS)) u_flags (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .ce_i      (ce_i),
      .fl        (fl)
   );

   // Summary is the OR of latched flags, power-up flag excluded
   assign any_fault = |fl.flags;

   // Power-up flag: low while supply is low, high after first clear
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pwr_flag_r <= 1'b0;
      end else if (ce_i) begin
         if (!ev_s[4]) begin
            pwr_flag_r <= 1'b0;
         end else if (clr_r) begin
            pwr_flag_r <= 1'b1;
         end
      end
   end

   // Open-drain fault pin, pulled low only while a fault is latched
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_out_low_pin_n_o  <= 1'b1;
         fault_out_low_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         fault_out_low_pin_n_o  <= ~any_fault;
         fault_out_low_pin_oe_o <= any_fault;
      end
   end

   // ***********************************************************
   // Measurement readouts
   // ***********************************************************
   // Duty holds its last value when regulation is off; do not rely on it
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         speed_r <= 8'h00;
         volt_r  <= 8'h00;
         curr_r  <= 8'h00;
         duty_r  <= 6'h00;
      end else if (ce_i) begin
         speed_r <= speed_est_i;
         volt_r  <= terminal_voltage_code_i;
         curr_r  <= winding_current_code_i;
         if (regulation_active_i) begin
            duty_r <= duty_cycle_i;
         end
      end
   end

   // ***********************************************************
   // Read multiplexer
   // ***********************************************************
   always_comb begin
      fault_byte = 8'h00;
      fault_byte[mdsr_pkg::BIT_FAULT] = any_fault;
      fault_byte[mdsr_pkg::BIT_STALL] = fl.flags[mdsr_pkg::FLG_STALL];
      fault_byte[mdsr_pkg::BIT_OVERCUR]  = fl.flags[mdsr_pkg::FLG_OVERCUR];
      fault_byte[mdsr_pkg::BIT_OVERVOLT] = fl.flags[mdsr_pkg::FLG_OVERVOLT];
      fault_byte[mdsr_pkg::BIT_THERMAL]  = fl.flags[mdsr_pkg::FLG_THERMAL];
      fault_byte[mdsr_pkg::BIT_PWR]   = pwr_flag_r;
   end

   // Reserved and unmapped offsets read zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (ptr_r)
         mdsr_pkg::OFS_FAULT: rd_byte = fault_byte;
         mdsr_pkg::OFS_SPEED: rd_byte = speed_r;
         mdsr_pkg::OFS_VOLT:  rd_byte = volt_r;
         mdsr_pkg::OFS_CURR:  rd_byte = curr_r;
         mdsr_pkg::OFS_DUTY:  rd_byte = {2'h0, duty_r};
         mdsr_pkg::OFS_CFG0:  rd_byte = fault_enable_config_o;
         mdsr_pkg::OFS_CFG1:  rd_byte = inrush_time_o[7:0];
         mdsr_pkg::OFS_CFG2:  rd_byte = inrush_time_o[15:8];
         mdsr_pkg::OFS_CFG3:  rd_byte = mode_config_o;
         mdsr_pkg::OFS_CFG4:  rd_byte = control_config_o;
         default:             rd_byte = 8'h00;
      endcase
   end

   // ***********************************************************
   // Serial register port engine
   // ***********************************************************
   // Sampling on rise, driving on fall; start and stop win over edges
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r  <= mdsr_pkg::S_IDLE;
         cnt_r    <= 4'h0;
         sh_r     <= 8'h00;
         tx_r     <= 8'h00;
         ptr_r    <= 8'h00;
         rw_r     <= 1'b0;
         nack_r   <= 1'b0;
         sda_oe_o <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_ofs_r <= 8'h00;
         wr_dat_r <= 8'h00;
      end else if (ce_i) begin
         wr_stb_r <= 1'b0;
         if (start_det) begin
            state_r  <= mdsr_pkg::S_ADDR;
            cnt_r    <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop_det) begin
            state_r  <= mdsr_pkg::S_IDLE;
            sda_oe_o <= 1'b0;
         end else if (scl_rise) begin
            unique case (state_r)
               mdsr_pkg::S_ADDR, mdsr_pkg::S_PTR, mdsr_pkg::S_WDATA: begin
                  sh_r  <= {sh_r[6:0], bus_s[0]};
                  cnt_r <= cnt_r + 4'h1;
               end
               mdsr_pkg::S_RACK: begin
                  nack_r <= bus_s[0];
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            unique case (state_r)
               mdsr_pkg::S_ADDR: begin
                  if (cnt_r == mdsr_pkg::BYTE_BITS) begin
                     if (sh_r[7:1] == DEV_ADDR) begin
                        rw_r     <= sh_r[0];
                        sda_oe_o <= 1'b1;
                        state_r  <= mdsr_pkg::S_AACK;
                     end else begin
                        state_r  <= mdsr_pkg::S_IDLE;
                     end
                  end
               end
               mdsr_pkg::S_AACK: begin
                  cnt_r <= 4'h0;
                  if (rw_r) begin
                     tx_r     <= {rd_byte[6:0], 1'b0};
                     sda_oe_o <= ~rd_byte[7];
                     ptr_r    <= ptr_nxt;
                     cnt_r    <= 4'h1;
                     state_r  <= mdsr_pkg::S_RDATA;
                  end else begin
                     sda_oe_o <= 1'b0;
                     state_r  <= mdsr_pkg::S_PTR;
                  end
               end
               mdsr_pkg::S_PTR: begin
                  if (cnt_r == mdsr_pkg::BYTE_BITS) begin
                     ptr_r    <= sh_r;
                     sda_oe_o <= 1'b1;
                     state_r  <= mdsr_pkg::S_PACK;
                  end
               end
               mdsr_pkg::S_PACK, mdsr_pkg::S_WACK: begin
                  sda_oe_o <= 1'b0;
                  cnt_r    <= 4'h0;
                  state_r  <= mdsr_pkg::S_WDATA;
               end
               mdsr_pkg::S_WDATA: begin
                  if (cnt_r == mdsr_pkg::BYTE_BITS) begin
                     wr_stb_r <= 1'b1;
                     wr_ofs_r <= ptr_r;
                     wr_dat_r <= sh_r;
                     ptr_r    <= ptr_nxt;
                     sda_oe_o <= 1'b1;
                     state_r  <= mdsr_pkg::S_WACK;
                  end
               end
               mdsr_pkg::S_RDATA: begin
                  if (cnt_r == mdsr_pkg::BYTE_BITS) begin
                     sda_oe_o <= 1'b0;
                     state_r  <= mdsr_pkg::S_RACK;
                  end else begin
                     sda_oe_o <= ~tx_r[7];
                     tx_r     <= {tx_r[6:0], 1'b0};
                     cnt_r    <= cnt_r + 4'h1;
                  end
               end
               mdsr_pkg::S_RACK: begin
                  if (nack_r) begin
                     state_r  <= mdsr_pkg::S_IDLE;
                  end else begin
                     tx_r     <= {rd_byte[6:0], 1'b0};
                     sda_oe_o <= ~rd_byte[7];
                     ptr_r    <= ptr_nxt;
                     cnt_r    <= 4'h1;
                     state_r  <= mdsr_pkg::S_RDATA;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Open-drain data line only ever pulls low
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sda_o <= 1'b0;
      end else if (ce_i) begin
         sda_o <= 1'b0;
      end
   end

   // ***********************************************************
   // Configuration registers
   // ***********************************************************
   // Status offsets and unmapped offsets fall through untouched
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_enable_config_o <= mdsr_pkg::RST_CFG0;
         inrush_time_o         <= {mdsr_pkg::RST_CFG2, mdsr_pkg::RST_CFG1};
         mode_config_o         <= mdsr_pkg::RST_CFG3;
         control_config_o      <= mdsr_pkg::RST_CFG4;
      end else if (ce_i && wr_stb_r) begin
         unique case (wr_ofs_r)
            mdsr_pkg::OFS_CFG0: begin
               // Clear bit never stored, so it reads back zero
               fault_enable_config_o <= wr_dat_r & mdsr_pkg::CFG0_WMASK;
            end
            mdsr_pkg::OFS_CFG1: inrush_time_o[7:0]  <= wr_dat_r;
            mdsr_pkg::OFS_CFG2: inrush_time_o[15:8] <= wr_dat_r;
            mdsr_pkg::OFS_CFG3: mode_config_o       <= wr_dat_r;
            mdsr_pkg::OFS_CFG4: control_config_o    <= wr_dat_r;
            default: begin
            end
         endcase
      end
   end

   // One-cycle clear pulse from a write of one to the clear bit
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clr_r <= 1'b0;
      end else if (ce_i) begin
         clr_r <= wr_stb_r && (wr_ofs_r == mdsr_pkg::OFS_CFG0) &&
                  wr_dat_r[mdsr_pkg::CFG0_CLR];
      end
   end

endmodule : mdsr_top
`default_nettype wire
